// ==== verilog/pad_ctrl.v ====
// Pad control registers and gating for ports A and B, Wishbone slave
// How it works
// - A port B pin's pull device is on when its pull enable bit is 1.
// - The pull device is forced off while the pin's direction is output.
// - The pull device is forced off while a peripheral drives the pin.
// - The pull device is kept off while an analog function owns the pin.
// - Pull direction 0 selects the pull-up and 1 selects the pull-down.
// - The selected pull device acts only when its enable bit is set.
// - Each of five port A slew bits turns on slew limiting when 1.
// - Each of eight port B slew bits turns on slew limiting when 1.
// - Slew limiting is ignored for a pin that is an input.
// - Port A has five drive select bits, one per pin.
// - Port B has eight drive select bits, one per pin.
// - Pad settings live apart from data and direction; only drive select acts alone.
// - A direction bit of 1 makes the pin an output, 0 an input.
`include "pad_ctrl_defs.vh"
module pad_ctrl (
    // Clock and reset
    input  wire        clk_i,
    input  wire        rst_i,
    // Wishbone classic slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [7:0]  adr_i,
    input  wire [3:0]  sel_i,
    input  wire [31:0] dat_i,
    output reg  [31:0] dat_o,
    output reg         ack_o,
    output reg         err_o,
    // Port A pin ownership
    input  wire [4:0]  pa_dir_i,
    input  wire [4:0]  pa_periph_out_i,
    // Port B pin ownership
    input  wire [7:0]  pb_dir_i,
    input  wire [7:0]  pb_periph_out_i,
    input  wire [7:0]  pb_analog_i,
    // Port A pad controls
    output reg  [4:0]  pa_slew_o,
    output reg  [4:0]  pa_drive_hi_o,
    // Port B pad controls
    output reg  [7:0]  pb_pull_up_o,
    output reg  [7:0]  pb_pull_down_o,
    output reg  [7:0]  pb_slew_o,
    output reg  [7:0]  pb_drive_hi_o
);

    // Register file
    reg  [4:0]  port_a_slew_enable_r;
    reg  [4:0]  port_a_drive_select_r;
    reg  [7:0]  port_b_pull_enable_r;
    reg  [7:0]  port_b_pull_direction_r;
    reg  [7:0]  port_b_slew_enable_r;
    reg  [7:0]  port_b_drive_select_r;

    // Bus decode
    wire        req;
    wire        wr;
    wire        hit;
    reg  [31:0] rd_nxt;

    // Gated results of both ports
    wire [4:0]  a_slew;
    wire [4:0]  a_drive;
    wire [7:0]  b_up;
    wire [7:0]  b_down;
    wire [7:0]  b_slew;
    wire [7:0]  b_drive;

    // Port A write values, cut to the five pins on purpose
    wire [7:0]  a_slew_wr;
    wire [7:0]  a_drive_wr;

    // Byte lane 0 write merge; only lane 0 carries register bits
    function [7:0] merge;
        input [7:0] old;
        input [7:0] new_val;
        input       lane;
        begin
            merge = lane ? new_val : old;
        end
    endfunction

    // Known address check, used for ack and err
    function known;
        input [7:0] a;
        begin
            known = (a == {4'h0, `OFF_PA_SLEW})
                 || (a == {4'h0, `OFF_PA_DRIVE})
                 || (a == {4'h0, `OFF_PB_PULL})
                 || (a == {4'h0, `OFF_PB_PULL_DIR})
                 || (a == `OFF_PB_SLEW)
                 || (a == `OFF_PB_DRIVE)
                 || (a == `OFF_PB_PAD_STAT);
        end
    endfunction

    // One answer per request; the answer cycle itself takes no new request
    assign req = cyc_i & stb_i & ~ack_o & ~err_o;
    assign hit = known(adr_i);
    assign wr  = req & we_i & hit;

    // Upper three bits of a port A write are dropped, they hold no pin
    assign a_slew_wr  = merge({3'h0, port_a_slew_enable_r}, dat_i[7:0],
                              sel_i[0]);
    assign a_drive_wr = merge({3'h0, port_a_drive_select_r}, dat_i[7:0],
                              sel_i[0]);

    // Control registers, cleared on reset and kept apart from pin data
    always @(posedge clk_i) begin
        if (rst_i) begin
            port_a_slew_enable_r    <= `RST_PA_CTRL;
            port_a_drive_select_r   <= `RST_PA_CTRL;
            port_b_pull_enable_r    <= `RST_PB_CTRL;
            port_b_pull_direction_r <= `RST_PB_CTRL;
            port_b_slew_enable_r    <= `RST_PB_CTRL;
            port_b_drive_select_r   <= `RST_PB_CTRL;
        end else if (wr) begin
            case (adr_i)
                {4'h0, `OFF_PA_SLEW}: begin
                    port_a_slew_enable_r <= a_slew_wr[4:0];
                end
                {4'h0, `OFF_PA_DRIVE}: begin
                    port_a_drive_select_r <= a_drive_wr[4:0];
                end
                {4'h0, `OFF_PB_PULL}: begin
                    port_b_pull_enable_r <= merge(
                        port_b_pull_enable_r, dat_i[7:0], sel_i[0]);
                end
                {4'h0, `OFF_PB_PULL_DIR}: begin
                    port_b_pull_direction_r <= merge(
                        port_b_pull_direction_r, dat_i[7:0], sel_i[0]);
                end
                `OFF_PB_SLEW: begin
                    port_b_slew_enable_r <= merge(
                        port_b_slew_enable_r, dat_i[7:0], sel_i[0]);
                end
                `OFF_PB_DRIVE: begin
                    port_b_drive_select_r <= merge(
                        port_b_drive_select_r, dat_i[7:0], sel_i[0]);
                end
                default: begin
                end
            endcase
        end
    end

    // Port A has no pull or analog path in this block
    pad_gate #(
        .N(`PA_PINS)
    ) u_gate_a (
        .pull_en_i    (5'h00),
        .pull_dir_i   (5'h00),
        .slew_en_i    (port_a_slew_enable_r),
        .drive_sel_i  (port_a_drive_select_r),
        .dir_i        (pa_dir_i),
        .periph_out_i (pa_periph_out_i),
        .analog_i     (5'h00),
        .pull_up_o    (),
        .pull_down_o  (),
        .slew_o       (a_slew),
        .drive_hi_o   (a_drive)
    );

    // Port B uses the full gating
    pad_gate #(
        .N(`PB_PINS)
    ) u_gate_b (
        .pull_en_i    (port_b_pull_enable_r),
        .pull_dir_i   (port_b_pull_direction_r),
        .slew_en_i    (port_b_slew_enable_r),
        .drive_sel_i  (port_b_drive_select_r),
        .dir_i        (pb_dir_i),
        .periph_out_i (pb_periph_out_i),
        .analog_i     (pb_analog_i),
        .pull_up_o    (b_up),
        .pull_down_o  (b_down),
        .slew_o       (b_slew),
        .drive_hi_o   (b_drive)
    );

    // Pad outputs registered so the pads see glitch-free levels
    always @(posedge clk_i) begin
        if (rst_i) begin
            pa_slew_o      <= 5'h00;
            pa_drive_hi_o  <= 5'h00;
            pb_pull_up_o   <= 8'h00;
            pb_pull_down_o <= 8'h00;
            pb_slew_o      <= 8'h00;
            pb_drive_hi_o  <= 8'h00;
        end else begin
            pa_slew_o      <= a_slew;
            pa_drive_hi_o  <= a_drive;
            pb_pull_up_o   <= b_up;
            pb_pull_down_o <= b_down;
            pb_slew_o      <= b_slew;
            pb_drive_hi_o  <= b_drive;
        end
    end

    // Read mux; status word shows which port B pulls are really active
    always @* begin
        rd_nxt = 32'h0000_0000;
        case (adr_i)
            {4'h0, `OFF_PA_SLEW}:     rd_nxt[4:0] = port_a_slew_enable_r;
            {4'h0, `OFF_PA_DRIVE}:    rd_nxt[4:0] = port_a_drive_select_r;
            {4'h0, `OFF_PB_PULL}:     rd_nxt[7:0] = port_b_pull_enable_r;
            {4'h0, `OFF_PB_PULL_DIR}: rd_nxt[7:0] = port_b_pull_direction_r;
            `OFF_PB_SLEW:             rd_nxt[7:0] = port_b_slew_enable_r;
            `OFF_PB_DRIVE:            rd_nxt[7:0] = port_b_drive_select_r;
            `OFF_PB_PAD_STAT:         rd_nxt[15:0] = {pb_pull_down_o,
                                                      pb_pull_up_o};
            default:                  rd_nxt = 32'h0000_0000;
        endcase
    end

    // Answer one cycle after the request; unmapped gets err
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            err_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= req & hit;
            err_o <= req & ~hit;
            dat_o <= (req & hit & ~we_i) ? rd_nxt : 32'h0000_0000;
        end
    end

    // Data and direction registers are outside; direction, peripheral and analog levels gate
    // the pull device, direction and peripheral levels gate slew limiting, drive select acts on its own

endmodule // pad_ctrl

// ==== verilog/pad_ctrl_defs.vh ====
// Register offsets, field widths and reset values of the pad control block
`ifndef PAD_CTRL_DEFS_VH
`define PAD_CTRL_DEFS_VH

// Byte offsets on the register bus (word aligned)
`define OFF_PA_SLEW      4'h0
`define OFF_PA_DRIVE     4'h4
`define OFF_PB_PULL      4'h8
`define OFF_PB_PULL_DIR  4'hC
`define OFF_PB_SLEW      8'h10
`define OFF_PB_DRIVE     8'h14
`define OFF_PB_PAD_STAT  8'h18

// Pin counts of the two ports
`define PA_PINS          5
`define PB_PINS          8

// Reset values of the control registers
`define RST_PA_CTRL      5'h00
`define RST_PB_CTRL      8'h00

`endif

// ==== verilog/pad_gate.v ====
// Per-pin gating of pull and slew controls for one port; drive select passes through ungated
module pad_gate #(
    parameter N = 8
) (
    // Control bits from registers
    input  wire [N-1:0] pull_en_i,
    input  wire [N-1:0] pull_dir_i,
    input  wire [N-1:0] slew_en_i,
    input  wire [N-1:0] drive_sel_i,
    // Pin ownership from the I/O logic
    input  wire [N-1:0] dir_i,
    input  wire [N-1:0] periph_out_i,
    input  wire [N-1:0] analog_i,
    // Gated pad controls
    output wire [N-1:0] pull_up_o,
    output wire [N-1:0] pull_down_o,
    output wire [N-1:0] slew_o,
    output wire [N-1:0] drive_hi_o
);

    wire [N-1:0] is_out;
    wire [N-1:0] pull_on;

    // A pin is an output when its direction bit or a peripheral drives it
    assign is_out  = dir_i | periph_out_i;
    // Pull only when enabled and not driven nor analog
    assign pull_on = pull_en_i & ~is_out & ~analog_i;
    // Direction 0 pulls up, 1 pulls down; nothing without enable
    assign pull_up_o   = pull_on & ~pull_dir_i;
    assign pull_down_o = pull_on & pull_dir_i;
    // Slew limiting means nothing on an input pin
    assign slew_o      = slew_en_i & is_out;
    // Drive select 1 is high drive
    assign drive_hi_o  = drive_sel_i;

endmodule // pad_gate

// ==== tb/pad_ctrl_properties.sv ====
// Checker of pad control bus answers and pin gating
module pad_ctrl_properties (
    // Clock, reset and bus
    input wire        clk_i,
    input wire        rst_i,
    input wire        cyc_i,
    input wire        stb_i,
    input wire [7:0]  adr_i,
    input wire [31:0] dat_o,
    input wire        ack_o,
    input wire        err_o,
    // Port B ownership and pads
    input wire [7:0]  pb_dir_i,
    input wire [7:0]  pb_periph_out_i,
    input wire [7:0]  pb_analog_i,
    input wire [7:0]  pb_pull_up_o,
    input wire [7:0]  pb_pull_down_o,
    input wire [7:0]  pb_slew_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // A fresh request; the answer cycle itself is never taken again
    wire req = cyc_i & stb_i & ~ack_o & ~err_o;
    wire hit = (adr_i <= 8'h18) && (adr_i[1:0] == 2'h0);
    wire [7:0] pulls = pb_pull_up_o | pb_pull_down_o;

    chk_req_ack: assert property (req && hit |=> ack_o && !err_o)
        else $error("mapped access not acknowledged");
    chk_req_err: assert property (req && !hit |=> err_o && !ack_o)
        else $error("unmapped access not refused");
    chk_ack_pulse: assert property (ack_o |=> !ack_o)
        else $error("ack longer than one cycle");
    chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0)
        else $error("read data outside ack");
    chk_pull_exclusive: assert property
        ((pb_pull_up_o & pb_pull_down_o) == 8'h0)
        else $error("pull-up and pull-down both on");
    chk_pull_output: assert property ((pulls & $past(pb_dir_i)) == 8'h0)
        else $error("pull on for output pin");
    chk_pull_periph: assert property ((pulls & $past(pb_periph_out_i)) == 8'h0)
        else $error("pull on for peripheral pin");
    chk_pull_analog: assert property ((pulls & $past(pb_analog_i)) == 8'h0)
        else $error("pull on for analog pin");
    chk_slew_input: assert property
        ((pb_slew_o & ~$past(pb_dir_i | pb_periph_out_i)) == 8'h0)
        else $error("slew on for input pin");
    chk_reset_clear: assert property
        ($fell(rst_i) |-> (pulls | pb_slew_o) == 8'h0)
        else $error("pads not cleared by reset");

    // Main scenarios reached
    cover property (ack_o);
    cover property (err_o);
    cover property (pb_pull_down_o != 8'h0);
endmodule // pad_ctrl_properties

bind pad_ctrl pad_ctrl_properties pad_ctrl_properties_inst (.*);

// ==== tb/pad_ctrl_tb.sv ====
// Self-checking bench of the pad control block
module pad_ctrl_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_i, rst_i, cyc_i, stb_i, we_i;
    logic [7:0]  adr_i, pb_dir_i, pb_periph_out_i, pb_analog_i;
    logic [3:0]  sel_i;
    logic [31:0] dat_i, dat_o, q;
    logic        ack_o, err_o, e;
    logic [4:0]  pa_dir_i, pa_periph_out_i, pa_slew_o, pa_drive_hi_o;
    logic [7:0]  pb_pull_up_o, pb_pull_down_o, pb_slew_o, pb_drive_hi_o;
    int          n_mismatch, check_count;
    // Rows: address, write data, read-back (port A keeps five bits)
    logic [7:0]  ra[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    logic [7:0]  rd[6] = '{8'hFF, 8'h15, 8'hFF, 8'h0F, 8'hFF, 8'hA5};
    logic [7:0]  rx[6] = '{8'h1F, 8'h15, 8'hFF, 8'h0F, 8'hFF, 8'hA5};

    pad_ctrl pad_ctrl_inst (.*);

    // Free-running bus clock
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    task automatic stop_test;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input string nm, input logic [47:0] s, x);
        check_count++;
        if (s !== x) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, x, s);
        end
    endtask

    // One classic cycle; ack or err is sampled at the rising edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= {24'h0, d};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 20);
        if (n >= 20) begin
            n_mismatch++;
            stop_test;
        end else begin
            q = dat_o;
            e = err_o;
            cyc_i <= 1'b0;
            stb_i <= 1'b0;
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] x);
        wb(1'b0, a, 8'h00);
        check("read", {16'h0, q}, {16'h0, x});
    endtask

    task automatic pads(input logic [41:0] x);
        repeat (2) @(posedge clk_i);
        check("pads", {pa_slew_o, pa_drive_hi_o, pb_pull_up_o, pb_pull_down_o,
                       pb_slew_o, pb_drive_hi_o}, {6'h0, x});
    endtask

    initial begin
        {cyc_i, stb_i, we_i, adr_i, dat_i} = '0;
        {pa_dir_i, pa_periph_out_i, pb_dir_i, pb_periph_out_i} = '0;
        pb_analog_i = 8'h00;
        sel_i = 4'hF;
        rst_i = 1'b1;
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 7; i++) rchk(8'(i * 4), 32'h0);
        pads(42'h0);
        $display("reset test done");
        // Ordinary cases: write each register, read it back
        for (int i = 0; i < 6; i++) begin
            wb(1'b1, ra[i], rd[i]);
            rchk(ra[i], {24'h0, rx[i]});
        end
        pads({5'h00, 5'h15, 8'hF0, 8'h0F, 8'h00, 8'hA5});
        $display("row test done");
        // Outputs, peripherals and analog owners gate the pulls
        pb_dir_i <= 8'h11;
        pb_periph_out_i <= 8'h22;
        pb_analog_i <= 8'h44;
        pa_dir_i <= 5'h01;
        pa_periph_out_i <= 5'h04;
        pads({5'h05, 5'h15, 8'h80, 8'h08, 8'h33, 8'hA5});
        rchk(8'h18, 32'h0880);
        $display("gating test done");
        // Refusals: unmapped, lane off, read-only status
        wb(1'b1, 8'h1C, 8'h00);
        check("err", {47'h0, e}, 48'h1);
        sel_i <= 4'h0;
        wb(1'b1, 8'h08, 8'h00);
        sel_i <= 4'hF;
        wb(1'b1, 8'h18, 8'hFF);
        rchk(8'h08, 32'hFF);
        rchk(8'h18, 32'h0880);
        $display("refusal test done");
        // Reset in mid-run clears everything again
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        pads(42'h0);
        rchk(8'h14, 32'h0);
        $display("second reset test done");
        stop_test;
    end
endmodule // pad_ctrl_tb
